//--- swrsc_pkg.sv
// Constants, types and register map of the sleep, wake and reset control block
package swrsc_pkg;

    localparam logic [15:0] SWRSC_FLAGS_OFS   = 16'hc000;
    localparam logic [15:0] SWRSC_BANK_OFS    = 16'hc002;
    localparam logic [15:0] SWRSC_REV_OFS     = 16'hc004;
    localparam logic [15:0] SWRSC_SPEED_OFS   = 16'hc008;
    localparam logic [15:0] SWRSC_PWR_OFS     = 16'hc00a;
    localparam logic [15:0] SWRSC_IRQEN_OFS   = 16'hc00e;
    localparam logic [15:0] SWRSC_BRK_OFS     = 16'hc014;
    localparam logic [15:0] SWRSC_USBDIAG_OFS = 16'hc03c;
    localparam logic [15:0] SWRSC_MEMDIAG_OFS = 16'hc03e;

    // Reset values
    localparam logic [11:0] SWRSC_BANK_RST    = 12'h010;
    localparam logic [3:0]  SWRSC_SPEED_RST   = 4'hf;
    localparam logic [15:0] SWRSC_PWR_RST     = 16'h0000;

    // Power control fields
    localparam int          SWRSC_PWR_HALT    = 0;
    localparam int          SWRSC_PWR_SLEEP   = 1;
    localparam int          SWRSC_PWR_BOOSTOK = 2;
    localparam int          SWRSC_PWR_GPI     = 4;
    localparam int          SWRSC_PWR_HPI     = 7;
    localparam int          SWRSC_PWR_SPI     = 8;
    localparam int          SWRSC_PWR_HSS     = 9;
    localparam int          SWRSC_PWR_OTG     = 11;
    localparam int          SWRSC_PWR_USB_LO  = 12;
    localparam logic [15:0] SWRSC_PWR_WR_MASK = 16'hfb93;

    // Boot addresses
    localparam logic [15:0] SWRSC_FETCH_ADDR  = 16'hff00;
    localparam logic [15:0] SWRSC_BIOS_ADDR   = 16'he000;

    // Timing at 100 MHz; longest times round down
    localparam int          SWRSC_CLK_PS      = 10000;
    localparam int          SWRSC_RESET_US    = 200;
    localparam int          SWRSC_SETTLE_US   = 200;
    localparam int          SWRSC_RESET_CYC   = (SWRSC_RESET_US * 1000000) / SWRSC_CLK_PS;
    localparam int          SWRSC_SETTLE_CYC  = (SWRSC_SETTLE_US * 1000000) / SWRSC_CLK_PS;

    typedef enum logic [2:0] {
        SWRSC_RST_WAIT = 3'b000,
        SWRSC_FETCH    = 3'b001,
        SWRSC_JUMP     = 3'b010,
        SWRSC_RUN      = 3'b011,
        SWRSC_SLEEP    = 3'b100,
        SWRSC_SETTLE   = 3'b101
    } swrsc_seq_type;

    typedef enum logic [2:0] {
        SWRSC_INT_RAM  = 3'b000,
        SWRSC_EXT_RAM  = 3'b001,
        SWRSC_CTRL_REG = 3'b010,
        SWRSC_EXT_ROM  = 3'b011,
        SWRSC_BOOT_ROM = 3'b100
    } swrsc_region_type;

endpackage

//--- swrsc_sysctl.sv
// Sleep, wakeup, boot sequencing, memory decode and processor control registers
`timescale 1ns/100ps
module swrsc_sysctl
    import swrsc_pkg::*;
#(
    parameter int          RESET_WAIT_CYCLES = SWRSC_RESET_CYC,
    parameter int          PLL_SETTLE_CYCLES = SWRSC_SETTLE_CYC,
    parameter logic [15:0] REVISION_ID       = 16'h0a5c  // Arbitrary value
)
(
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    input  wire logic [4:0]  CPU_FLAGS,
    input  wire logic [3:0]  REG_NUM,
    output logic      [15:0] BANK_ADDR,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic        CPU_MEM_REQ,
    output logic      [15:0] EXT_ADDR,
    output logic             EXT_RAM_SELECT_N,
    output logic             EXT_ROM_SELECT_N,
    output logic      [2:0]  MEM_REGION,
    input  wire logic [3:0]  USB_RESUME,
    input  wire logic        OTG_BUS_POWER,
    input  wire logic        OTG_ROLE_PIN,
    input  wire logic        EXT_WAKE_LINE_A,
    input  wire logic        EXT_WAKE_LINE_B,
    input  wire logic        BOOST_OK,
    input  wire logic        PARALLEL_HOST_PORT_READ,
    input  wire logic        FAST_SERIAL_PORT_READ,
    input  wire logic        SPI_PORT_READ,
    input  wire logic        HOST_IRQ_ACK,
    input  wire logic        USB_BUS_RESET,
    output logic             WAKE_READ_DUMMY,
    output logic             HOST_PORT_IRQ,
    output logic             GPIO_HOLD,
    output logic             CRYSTAL_DRIVE_OUT_EN,
    output logic             PLL_EN,
    output logic             BOOSTER_EN,
    output logic             USB_XCVR_EN,
    output logic             CHARGE_PUMP_OFF,
    output logic             CPU_RUN,
    output logic             CPU_HALT,
    output logic             CPU_PC_LOAD,
    output logic      [15:0] CPU_PC,
    output logic      [3:0]  CORE_DIV,
    output logic      [15:0] IRQ_ENABLE,
    output logic      [15:0] BREAK_ADDR,
    output logic      [15:0] USB_DIAG,
    output logic      [15:0] MEM_DIAG,
    output logic             USB_REG_RESET
);

    typedef struct packed {
        swrsc_seq_type    st;
        logic [14:0]      cnt;
        logic [8:0]       sy1;
        logic [8:0]       sy2;
        logic [8:0]       sy3;
        logic [8:0]       pin;
        logic [11:0]      bank;
        logic [3:0]       speed;
        logic [15:0]      pwr;
        logic [15:0]      irqen;
        logic [15:0]      brk;
        logic [15:0]      usbdiag;
        logic [15:0]      memdiag;
        logic [15:0]      rdata;
        logic [15:0]      bank_addr;
        logic [15:0]      ext_addr;
        logic             ram_sel_n;
        logic             rom_sel_n;
        swrsc_region_type region;
        logic             gpio_hold;
        logic             xtal_en;
        logic             pll_en;
        logic             boost_en;
        logic             xcvr_en;
        logic             pump_off;
        logic             cpu_run;
        logic             pc_load;
        logic [15:0]      pc;
        logic             host_irq;
        logic             dummy;
        logic             usb_rst;
    } swrsc_state_type;

    swrsc_state_type s_q;
    swrsc_state_type s_d;

    logic [8:0] pins;
    logic [8:0] agree;
    logic [8:0] chg;
    logic       usb_wake;
    logic       otg_wake;
    logic       gpi_wake;
    logic       read_wake;
    logic       any_wake;

    // Byte-addressed 64K space, five regions
    function automatic swrsc_region_type mem_region(input logic [15:0] a);
        if (a < 16'h4000)
            mem_region = SWRSC_INT_RAM;
        else if (a < 16'hc000)
            mem_region = SWRSC_EXT_RAM;
        else if (a < 16'hc100)
            mem_region = SWRSC_CTRL_REG;
        else if (a < 16'he000)
            mem_region = SWRSC_EXT_ROM;
        else
            mem_region = SWRSC_BOOT_ROM;
    endfunction

    function automatic logic [15:0] bank_map(input logic [11:0] base, input logic [3:0] num);
        bank_map = ({base, 4'h0} | {11'h000, num, 1'b0}) & 16'hfffe;
    endfunction

    // Pin order: resume[3:0], bus power, role, line A, line B, booster ok
    assign pins  = {BOOST_OK, EXT_WAKE_LINE_B, EXT_WAKE_LINE_A, OTG_ROLE_PIN, OTG_BUS_POWER, USB_RESUME};
    assign agree = ~(s_q.sy2 ^ s_q.sy3);
    assign chg   = agree & (s_q.sy3 ^ s_q.pin);

    assign usb_wake  = |(s_q.pin[3:0] & s_q.pwr[15:SWRSC_PWR_USB_LO]);
    assign otg_wake  = s_q.pwr[SWRSC_PWR_OTG] & (s_q.pin[4] | chg[5]);
    assign gpi_wake  = s_q.pwr[SWRSC_PWR_GPI] & (chg[6] | chg[7]);
    assign read_wake = (PARALLEL_HOST_PORT_READ & s_q.pwr[SWRSC_PWR_HPI])
                     | (FAST_SERIAL_PORT_READ & s_q.pwr[SWRSC_PWR_HSS])
                     | (SPI_PORT_READ & s_q.pwr[SWRSC_PWR_SPI]);
    assign any_wake  = usb_wake | otg_wake | gpi_wake | read_wake;

    always_comb
    begin
        s_d = s_q;
        s_d.sy1 = pins;
        s_d.sy2 = s_q.sy1;
        s_d.sy3 = s_q.sy2;
        s_d.pin = (s_q.pin & ~agree) | (s_q.sy3 & agree);
        s_d.rdata = 16'h0000;
        s_d.pc_load = 1'b0;
        s_d.dummy = 1'b0;
        // USB reset only signals the two USB registers
        s_d.usb_rst = USB_BUS_RESET;

        // Register writes; read-only ones ignore writes
        if (REG_WR)
        begin
            case (REG_ADDR)
                SWRSC_BANK_OFS:    s_d.bank = REG_WDATA[15:4];
                SWRSC_SPEED_OFS:   s_d.speed = REG_WDATA[3:0];
                // Sleep, halt and wake enables writable
                SWRSC_PWR_OFS:     s_d.pwr = REG_WDATA & SWRSC_PWR_WR_MASK;
                SWRSC_IRQEN_OFS:   s_d.irqen = REG_WDATA;
                SWRSC_BRK_OFS:     s_d.brk = REG_WDATA;
                SWRSC_USBDIAG_OFS: s_d.usbdiag = REG_WDATA;
                SWRSC_MEMDIAG_OFS: s_d.memdiag = REG_WDATA;
                default:           s_d.rdata = 16'h0000;
            endcase
        end

        // Reads; write-only and unmapped read zero
        if (REG_RD)
        begin
            case (REG_ADDR)
                SWRSC_FLAGS_OFS: s_d.rdata = {11'h000, CPU_FLAGS};
                SWRSC_BANK_OFS:  s_d.rdata = {s_q.bank, 4'h0};
                SWRSC_REV_OFS:   s_d.rdata = REVISION_ID;
                SWRSC_SPEED_OFS: s_d.rdata = {12'h000, s_q.speed};
                SWRSC_PWR_OFS:   s_d.rdata = s_q.pwr | {13'h0000, s_q.pin[8], 2'b00};
                SWRSC_IRQEN_OFS: s_d.rdata = s_q.irqen;
                SWRSC_BRK_OFS:   s_d.rdata = s_q.brk;
                default:         s_d.rdata = 16'h0000;
            endcase
        end

        s_d.bank_addr = bank_map(s_q.bank, REG_NUM);

        case (s_q.st)
            // Boot wait, then fetch and jump
            SWRSC_RST_WAIT:
            begin
                s_d.cnt = s_q.cnt - 15'h0001;
                if (s_q.cnt == 15'h0000)
                begin
                    s_d.st = SWRSC_FETCH;
                    s_d.pc = SWRSC_FETCH_ADDR;
                    s_d.pc_load = 1'b1;
                end
            end
            SWRSC_FETCH:
            begin
                s_d.st = SWRSC_JUMP;
                s_d.pc = SWRSC_BIOS_ADDR;
                s_d.pc_load = 1'b1;
            end
            SWRSC_JUMP:
                s_d.st = SWRSC_RUN;
            SWRSC_RUN:
                if (s_q.pwr[SWRSC_PWR_SLEEP])
                    s_d.st = SWRSC_SLEEP;
            SWRSC_SLEEP:
                if (any_wake)
                begin
                    s_d.st = SWRSC_SETTLE;
                    s_d.cnt = 15'(PLL_SETTLE_CYCLES - 1);
                    s_d.pwr[SWRSC_PWR_SLEEP] = 1'b0;
                    s_d.dummy = read_wake;
                end
            SWRSC_SETTLE:
            begin
                s_d.cnt = s_q.cnt - 15'h0001;
                if (s_q.cnt == 15'h0000)
                    s_d.st = SWRSC_RUN;
            end
            default:
                s_d.st = SWRSC_RUN;
        endcase

        // Resume wake sets host interrupt; set wins over ack
        s_d.host_irq = (s_q.host_irq & ~HOST_IRQ_ACK) | ((s_q.st == SWRSC_SLEEP) & usb_wake);

        s_d.gpio_hold = (s_d.st == SWRSC_SLEEP);
        s_d.xtal_en = (s_d.st != SWRSC_SLEEP);
        s_d.pll_en = (s_d.st != SWRSC_SLEEP);
        s_d.boost_en = (s_d.st != SWRSC_SLEEP);
        s_d.xcvr_en = (s_d.st != SWRSC_SLEEP);
        // Pump forced off so bus supply drains fully
        s_d.pump_off = (s_d.st == SWRSC_SLEEP);
        s_d.cpu_run = (s_d.st == SWRSC_RUN);

        s_d.region = mem_region(CPU_ADDR);
        s_d.ext_addr = (s_d.st == SWRSC_SLEEP) ? 16'h0000 : CPU_ADDR;
        // Chip selects only for external regions
        s_d.ram_sel_n = ~(CPU_MEM_REQ & (s_d.region == SWRSC_EXT_RAM) & (s_d.st != SWRSC_SLEEP));
        s_d.rom_sel_n = ~(CPU_MEM_REQ & (s_d.region == SWRSC_EXT_ROM) & (s_d.st != SWRSC_SLEEP));
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            // Every register back to its default
            s_q <= '0;
            s_q.st <= SWRSC_RST_WAIT;
            s_q.cnt <= 15'(RESET_WAIT_CYCLES - 1);
            s_q.bank <= SWRSC_BANK_RST;
            s_q.speed <= SWRSC_SPEED_RST;
            s_q.pwr <= SWRSC_PWR_RST;
            s_q.bank_addr <= {SWRSC_BANK_RST, 4'h0};
            s_q.ram_sel_n <= 1'b1;
            s_q.rom_sel_n <= 1'b1;
            s_q.xtal_en <= 1'b1;
            s_q.pll_en <= 1'b1;
            s_q.boost_en <= 1'b1;
            s_q.xcvr_en <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign REG_RDATA            = s_q.rdata;
    assign BANK_ADDR            = s_q.bank_addr;
    assign EXT_ADDR             = s_q.ext_addr;
    assign EXT_RAM_SELECT_N     = s_q.ram_sel_n;
    assign EXT_ROM_SELECT_N     = s_q.rom_sel_n;
    assign MEM_REGION           = s_q.region;
    assign WAKE_READ_DUMMY      = s_q.dummy;
    assign HOST_PORT_IRQ        = s_q.host_irq;
    assign GPIO_HOLD            = s_q.gpio_hold;
    assign CRYSTAL_DRIVE_OUT_EN = s_q.xtal_en;
    assign PLL_EN               = s_q.pll_en;
    assign BOOSTER_EN           = s_q.boost_en;
    assign USB_XCVR_EN          = s_q.xcvr_en;
    assign CHARGE_PUMP_OFF      = s_q.pump_off;
    assign CPU_RUN              = s_q.cpu_run;
    assign CPU_HALT             = s_q.pwr[SWRSC_PWR_HALT];
    assign CPU_PC_LOAD          = s_q.pc_load;
    assign CPU_PC               = s_q.pc;
    assign CORE_DIV             = s_q.speed;
    assign IRQ_ENABLE           = s_q.irqen;
    assign BREAK_ADDR           = s_q.brk;
    assign USB_DIAG             = s_q.usbdiag;
    assign MEM_DIAG             = s_q.memdiag;
    assign USB_REG_RESET        = s_q.usb_rst;

    // Settle age counter, only checked below
    logic [15:0] settle_age_q;
    always_ff @(posedge CLOCK)
    begin
        if (SRST || s_q.st != SWRSC_SETTLE)
            settle_age_q <= 16'h0000;
        else
            settle_age_q <= settle_age_q + 16'h0001;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence boot_fetch_s;
        s_q.st == SWRSC_FETCH && CPU_PC_LOAD && CPU_PC == 16'hff00;
    endsequence
    sequence boot_jump_s;
        CPU_PC_LOAD && CPU_PC == 16'he000 ##1 CPU_RUN;
    endsequence

    sleep_power_off_a: assert property (s_q.st == SWRSC_SLEEP |-> !PLL_EN && !CRYSTAL_DRIVE_OUT_EN
        && !BOOSTER_EN && !USB_XCVR_EN && GPIO_HOLD) else $error("power not off in sleep");
    sleep_addr_low_a: assert property (s_q.st == SWRSC_SLEEP |-> EXT_ADDR == 16'h0000)
        else $error("address not low in sleep");
    sel_internal_a: assert property (mem_region($past(CPU_ADDR)) inside {SWRSC_INT_RAM, SWRSC_CTRL_REG,
        SWRSC_BOOT_ROM} |-> EXT_RAM_SELECT_N && EXT_ROM_SELECT_N) else $error("select on internal access");
    ram_select_a: assert property ($past(CPU_MEM_REQ) && $past(CPU_ADDR) >= 16'h4000 && !$past(SRST)
        && $past(CPU_ADDR) <= 16'hbfff && s_q.st != SWRSC_SLEEP |-> !EXT_RAM_SELECT_N) else $error("ram select");
    rom_select_a: assert property ($past(CPU_MEM_REQ) && $past(CPU_ADDR) >= 16'hc100 && !$past(SRST)
        && $past(CPU_ADDR) <= 16'hdfff && s_q.st != SWRSC_SLEEP |-> !EXT_ROM_SELECT_N) else $error("rom select");
    settle_bound_a: assert property (settle_age_q <= 16'(PLL_SETTLE_CYCLES))
        else $error("settle too long");
    wake_ignore_a: assert property (s_q.st == SWRSC_SLEEP && !any_wake |=> s_q.st == SWRSC_SLEEP && !CPU_RUN)
        else $error("woke without enabled event");
    boot_order_a: assert property (boot_fetch_s |=> boot_jump_s)
        else $error("boot fetch order wrong");
    resume_irq_a: assert property (s_q.st == SWRSC_SLEEP && usb_wake |=> HOST_PORT_IRQ && s_q.st == SWRSC_SETTLE)
        else $error("no host irq on resume");
    dummy_read_a: assert property (s_q.st == SWRSC_SLEEP && read_wake |=> WAKE_READ_DUMMY)
        else $error("waking read not marked dummy");

endmodule

//--- swrsc_host_model.sv
// Model of the external host ports that read the device
`timescale 1ns/100ps
module swrsc_host_model
(
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic [1:0] port_sel,
    input  wire logic       read_dummy,
    output logic            host_rd,
    output logic            serial_rd,
    output logic            spi_rd,
    output logic            dummy_seen
);
    initial
    begin
        host_rd    = 1'b0;
        serial_rd  = 1'b0;
        spi_rd     = 1'b0;
        dummy_seen = 1'b0;
    end

    always @(posedge clock)
    begin
        host_rd   <= start && (port_sel == 2'd0);
        serial_rd <= start && (port_sel == 2'd1);
        spi_rd    <= start && (port_sel == 2'd2);
        if (start)
            dummy_seen <= 1'b0;
        else if (read_dummy)
            dummy_seen <= 1'b1;
    end
endmodule

//--- swrsc_sysctl_bench.sv
// Self-checking bench of the sleep, wake and reset control block
`timescale 1ns/100ps
module swrsc_sysctl_bench
    import swrsc_pkg::*;
;
    localparam int          WAIT_C   = 20;
    localparam int          SETTLE_C = 20;
    localparam logic [15:0] REV      = 16'h1357;  // Arbitrary value

    logic        CLOCK = 1'b0, SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, CPU_MEM_REQ = 1'b1;
    logic [15:0] REG_ADDR = 16'h0, REG_WDATA = 16'h0, CPU_ADDR = 16'h0;
    logic [4:0]  CPU_FLAGS = 5'h15;
    logic [3:0]  REG_NUM = 4'he, USB_RESUME = 4'h0;
    logic        OTG_BUS_POWER = 1'b0, OTG_ROLE_PIN = 1'b0, EXT_WAKE_LINE_A = 1'b0, EXT_WAKE_LINE_B = 1'b0;
    logic        BOOST_OK = 1'b0, HOST_IRQ_ACK = 1'b0, USB_BUS_RESET = 1'b0, start = 1'b0;
    logic [1:0]  port_sel = 2'd0;
    logic        PARALLEL_HOST_PORT_READ, FAST_SERIAL_PORT_READ, SPI_PORT_READ, dummy_seen;
    logic [15:0] REG_RDATA, BANK_ADDR, EXT_ADDR, CPU_PC, IRQ_ENABLE, BREAK_ADDR, USB_DIAG, MEM_DIAG;
    logic        EXT_RAM_SELECT_N, EXT_ROM_SELECT_N, WAKE_READ_DUMMY, HOST_PORT_IRQ, GPIO_HOLD;
    logic        CRYSTAL_DRIVE_OUT_EN, PLL_EN, BOOSTER_EN, USB_XCVR_EN, CHARGE_PUMP_OFF;
    logic        CPU_RUN, CPU_HALT, CPU_PC_LOAD, USB_REG_RESET;
    logic [2:0]  MEM_REGION;
    logic [3:0]  CORE_DIV;
    int          err_total = 0, samples_checked = 0;
    logic [15:0] dec_a [10] = '{16'h0000, 16'h3fff, 16'h4000, 16'hbfff, 16'hc000, 16'hc0ff, 16'hc100,
                                16'hdfff, 16'he000, 16'hffff};
    logic [4:0]  dec_e [10] = '{5'h03, 5'h03, 5'h05, 5'h05, 5'h0b, 5'h0b, 5'h0e, 5'h0e, 5'h13, 5'h13};
    logic [15:0] en [8] = '{16'h1000, 16'h0800, 16'h0800, 16'h0010, 16'h0010, 16'h0080, 16'h0200, 16'h0100};

    swrsc_sysctl #(.RESET_WAIT_CYCLES(WAIT_C), .PLL_SETTLE_CYCLES(SETTLE_C), .REVISION_ID(REV)) i_dut (
        .CLOCK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CPU_FLAGS, .REG_NUM, .BANK_ADDR,
        .CPU_ADDR, .CPU_MEM_REQ, .EXT_ADDR, .EXT_RAM_SELECT_N, .EXT_ROM_SELECT_N, .MEM_REGION, .USB_RESUME,
        .OTG_BUS_POWER, .OTG_ROLE_PIN, .EXT_WAKE_LINE_A, .EXT_WAKE_LINE_B, .BOOST_OK, .PARALLEL_HOST_PORT_READ,
        .FAST_SERIAL_PORT_READ, .SPI_PORT_READ, .HOST_IRQ_ACK, .USB_BUS_RESET, .WAKE_READ_DUMMY, .HOST_PORT_IRQ,
        .GPIO_HOLD, .CRYSTAL_DRIVE_OUT_EN, .PLL_EN, .BOOSTER_EN, .USB_XCVR_EN, .CHARGE_PUMP_OFF, .CPU_RUN,
        .CPU_HALT, .CPU_PC_LOAD, .CPU_PC, .CORE_DIV, .IRQ_ENABLE, .BREAK_ADDR, .USB_DIAG, .MEM_DIAG,
        .USB_REG_RESET);

    swrsc_host_model i_host (.clock(CLOCK), .start(start), .port_sel(port_sel), .read_dummy(WAKE_READ_DUMMY),
        .host_rd(PARALLEL_HOST_PORT_READ), .serial_rd(FAST_SERIAL_PORT_READ), .spi_rd(SPI_PORT_READ),
        .dummy_seen(dummy_seen));

    always #5 CLOCK = ~CLOCK;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLOCK);
        REG_WR    <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [15:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLOCK);
        REG_RD   <= 1'b0;
        #1;
        chk(nm, e, REG_RDATA & m);
    endtask

    // Power-state outputs packed for one compare
    function automatic logic [15:0] slp();
        return {9'h0, CRYSTAL_DRIVE_OUT_EN, PLL_EN, BOOSTER_EN, USB_XCVR_EN, GPIO_HOLD, CHARGE_PUMP_OFF, CPU_RUN};
    endfunction

    // Call right after a rising edge
    task automatic fire(input int s);
        case (s)
            0: USB_RESUME <= 4'h1;
            1: OTG_BUS_POWER <= 1'b1;
            2: OTG_ROLE_PIN <= ~OTG_ROLE_PIN;
            3: EXT_WAKE_LINE_A <= ~EXT_WAKE_LINE_A;
            4: EXT_WAKE_LINE_B <= ~EXT_WAKE_LINE_B;
            default:
            begin
                start    <= 1'b1;
                port_sel <= 2'(s - 5);
            end
        endcase
    endtask

    task automatic boot();
        int n;
        n = 0;
        @(posedge CLOCK);
        SRST <= 1'b0;
        tick(1);
        while (CPU_PC_LOAD !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        chk("boot_wait", 16'h1, {15'h0, n >= WAIT_C - 2 && n <= WAIT_C + 4});
        chk("fetch_pc", SWRSC_FETCH_ADDR, CPU_PC);
        tick(1);
        chk("jump_pc", SWRSC_BIOS_ADDR, (CPU_PC_LOAD === 1'b1) ? CPU_PC : 16'h0);
        n = 0;
        while (CPU_RUN !== 1'b1 && n < 3)
        begin
            tick(1);
            n++;
        end
        chk("run_after_boot", 16'h1, {15'h0, CPU_RUN});
    endtask

    initial
    begin
        #100000;
        err_total++;
        stop_test();
    end

    initial
    begin
        int n;
        repeat (5) @(posedge CLOCK);
        boot();
        rd("flags", SWRSC_FLAGS_OFS, 16'h0015);
        @(posedge CLOCK);
        CPU_FLAGS <= 5'h0a;
        rd("flags", SWRSC_FLAGS_OFS, 16'h000a);
        rd("bank_reset", SWRSC_BANK_OFS, 16'h0100, 16'hfff0);
        rd("revision", SWRSC_REV_OFS, REV);
        rd("speed_reset", SWRSC_SPEED_OFS, 16'h000f);
        rd("power_reset", SWRSC_PWR_OFS, 16'h0000);
        chk("bank_addr", 16'h011c, BANK_ADDR);
        wr(SWRSC_FLAGS_OFS, 16'hffff);
        wr(SWRSC_REV_OFS, 16'hffff);
        rd("flags_ro", SWRSC_FLAGS_OFS, 16'h000a);
        rd("revision_ro", SWRSC_REV_OFS, REV);
        wr(SWRSC_BANK_OFS, 16'habcf);
        rd("bank_rw", SWRSC_BANK_OFS, 16'habc0, 16'hfff0);
        @(posedge CLOCK);
        REG_NUM <= 4'hf;
        tick(2);
        chk("bank_addr", 16'habde, BANK_ADDR);
        wr(SWRSC_IRQEN_OFS, 16'ha5a5);
        rd("irq_enable", SWRSC_IRQEN_OFS, 16'ha5a5);
        chk("irq_enable_out", 16'ha5a5, IRQ_ENABLE);
        wr(SWRSC_BRK_OFS, 16'h1234);
        rd("break_addr", SWRSC_BRK_OFS, 16'h1234);
        chk("break_addr_out", 16'h1234, BREAK_ADDR);
        wr(SWRSC_USBDIAG_OFS, 16'h0f0f);
        rd("usb_diag_wo", SWRSC_USBDIAG_OFS, 16'h0000);
        chk("usb_diag", 16'h0f0f, USB_DIAG);
        wr(SWRSC_MEMDIAG_OFS, 16'hf0f0);
        rd("mem_diag_wo", SWRSC_MEMDIAG_OFS, 16'h0000);
        chk("mem_diag", 16'hf0f0, MEM_DIAG);
        rd("unmapped", 16'hc006, 16'h0000);
        wr(SWRSC_SPEED_OFS, 16'h0003);
        rd("speed", SWRSC_SPEED_OFS, 16'h0003);
        chk("core_div", 16'h0003, {12'h0, CORE_DIV});
        for (int i = 0; i < 10; i++)
        begin
            @(posedge CLOCK);
            CPU_ADDR <= dec_a[i];
            tick(2);
            chk("decode", {11'h0, dec_e[i]}, {11'h0, MEM_REGION, EXT_RAM_SELECT_N, EXT_ROM_SELECT_N});
            chk("ext_addr", dec_a[i], EXT_ADDR);
        end
        // No request, no select even in the external window
        @(posedge CLOCK);
        CPU_MEM_REQ <= 1'b0;
        CPU_ADDR    <= 16'h4000;
        tick(2);
        chk("no_req_select", 16'h0007, {11'h0, MEM_REGION, EXT_RAM_SELECT_N, EXT_ROM_SELECT_N});
        @(posedge CLOCK);
        CPU_MEM_REQ <= 1'b1;
        BOOST_OK <= 1'b1;
        tick(6);
        // Reserved bits written high must not stick; bit 2 mirrors the booster
        wr(SWRSC_PWR_OFS, 16'h046d);
        rd("power_mask", SWRSC_PWR_OFS, 16'h0005);
        chk("halt", 16'h1, {15'h0, CPU_HALT});
        wr(SWRSC_PWR_OFS, 16'h0000);
        tick(2);
        chk("halt", 16'h0, {15'h0, CPU_HALT});
        @(posedge CLOCK);
        USB_BUS_RESET <= 1'b1;
        @(posedge CLOCK);
        USB_BUS_RESET <= 1'b0;
        #1;
        chk("usb_reg_reset", 16'h1, {15'h0, USB_REG_RESET});
        rd("speed_kept", SWRSC_SPEED_OFS, 16'h0003);
        @(posedge CLOCK);
        CPU_ADDR <= 16'h8421;
        for (int s = 0; s < 8; s++)
        begin
            wr(SWRSC_PWR_OFS, 16'h0002 | en[s]);
            tick(4);
            chk("sleep_state", 16'h0006, slp());
            chk("sleep_addr", 16'h0000, EXT_ADDR);
            @(posedge CLOCK);
            fire(s == 7 ? 5 : 7);
            @(posedge CLOCK);
            start <= 1'b0;
            tick(10);
            chk("stay_asleep", 16'h0006, slp());
            @(posedge CLOCK);
            fire(s);
            @(posedge CLOCK);
            start <= 1'b0;
            n = 0;
            while (CPU_RUN !== 1'b1 && n < 200)
            begin
                tick(1);
                n++;
            end
            chk("wake_time", 16'h1, {15'h0, n <= SETTLE_C + 12});
            chk("awake_state", 16'h0079, slp());
            chk("host_irq", {15'h0, s == 0}, {15'h0, HOST_PORT_IRQ});
            chk("dummy_read", {15'h0, s >= 5}, {15'h0, dummy_seen});
            rd("sleep_bit", SWRSC_PWR_OFS, 16'h0000, 16'h0002);
            @(posedge CLOCK);
            USB_RESUME    <= 4'h0;
            OTG_BUS_POWER <= 1'b0;
            HOST_IRQ_ACK  <= 1'b1;
            @(posedge CLOCK);
            HOST_IRQ_ACK  <= 1'b0;
            tick(6);
        end
        @(posedge CLOCK);
        SRST <= 1'b1;
        repeat (140) @(posedge CLOCK);
        #1;
        chk("reset_div", 16'h000f, {12'h0, CORE_DIV});
        boot();
        rd("speed_reset", SWRSC_SPEED_OFS, 16'h000f);
        rd("bank_reset", SWRSC_BANK_OFS, 16'h0100, 16'hfff0);
        stop_test();
    end
endmodule
